// ### hw/pdpi_cfg.svh
// Timing and layout constants for the pager decoder pin interface.
`ifndef PDPI_CFG_SVH
`define PDPI_CFG_SVH
`define PDPI_REF_HZ          40000000
`define PDPI_OSC_HZ          76800
`define PDPI_OUT_HZ          38400
`define PDPI_OSC_HALF_CYC    ((`PDPI_REF_HZ / `PDPI_OSC_HZ) / 2)
`define PDPI_INIT_US         100
`define PDPI_INIT_CYC        ((`PDPI_INIT_US * (`PDPI_REF_HZ / 1000000)))
`define PDPI_WORD_BITS       8
`define PDPI_SYM_BITS        2
`define PDPI_RX_CTRL_BITS    8
`define PDPI_RX_CTRL_RST     8'h00
`define PDPI_TX_IDLE         8'hFF
`endif

// ### hw/pdpi_pkg.sv
// Types shared by the pager decoder pin interface.
package pdpi_pkg;
    typedef struct packed {
        logic sclk;
        logic sel_n;
        logic mosi;
    } pdpi_spi_in_t;
    typedef enum logic [1:0] {
        PDPI_RESET = 2'b00,
        PDPI_INIT  = 2'b01,
        PDPI_READY = 2'b11,
        PDPI_XFER  = 2'b10
    } pdpi_state_t;
endpackage

// ### hw/pdpi_top.sv
// Pin interface of the pager decoder: SPI slave, clocks, symbols and receiver controls.
// Notes on behaviour
// - A divided clock output runs at half the 76.8 kHz oscillator rate, 38.4 kHz.
// - A bypass strap picks between the internal oscillator and an external clock.
// - Driving the active-low reset low initialises all state into the reset state.
// - The two symbol inputs form one symbol, high input as MSB and low input as LSB.
// - Serial clock activity is ignored while slave select is not asserted.
// - The device is always a slave and never drives the serial clock.
// - Transfers happen only while the master holds slave select asserted.
// - Data is received on MOSI and sent on MISO in full duplex in the same transfer.
// - MISO is the only serial output and is high impedance during reset.
// - Ready is high during reset and goes low only when a packet can be accepted.
// - Eight receiver control outputs exist and are high impedance during reset.
// - A recovered symbol clock is derived from symbol timing and aligned to the clock.
`timescale 1ns/1ps
`default_nettype none
`include "pdpi_cfg.svh"
module pdpi_top #(
    parameter int INIT_CYC = `PDPI_INIT_CYC,
    parameter int W        = `PDPI_WORD_BITS
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  arst_n_i,
    input  wire logic                  oscillator_input_i,
    input  wire logic                  oscillator_bypass_strap_i,
    input  wire logic                  low_battery_input_i,
    input  wire logic                  symbol_high_bit_input_i,
    input  wire logic                  symbol_low_bit_input_i,
    input  wire pdpi_pkg::pdpi_spi_in_t spi_i,
    input  wire logic [W-1:0]          tx_word_i,
    input  wire logic [7:0]            rx_ctrl_i,
    output logic                       miso_o,
    output logic                       miso_oe_n_o,
    output logic                       ready_o,
    output logic                       oscillator_output_o,
    output logic                       divided_clock_output_o,
    output logic                       recovered_symbol_clock_o,
    output logic [7:0]                 receiver_control_outputs_o,
    output logic [7:0]                 receiver_control_oe_n_o,
    output logic [W-1:0]               rx_word_o,
    output logic                       rx_valid_o,
    output logic [1:0]                 symbol_o,
    output logic                       low_battery_o
);
    import pdpi_pkg::*;

    localparam int HALF = `PDPI_OSC_HALF_CYC;
    localparam int CW   = $clog2(INIT_CYC + HALF + 1);

    // Three-stage synchronisers; a change counts once stages two and three agree.
    logic [2:0] sclk_s, sel_s, mosi_s, xosc_s, sym1_s, sym0_s, lob_s;
    logic       sclk_q, sel_n_q, mosi_q, xosc_q, sym1_q, sym0_q;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_s <= 3'h0; sel_s <= 3'h7; mosi_s <= 3'h0; xosc_s <= 3'h0;
            sym1_s <= 3'h0; sym0_s <= 3'h0; lob_s <= 3'h0;
            sclk_q <= 1'b0; sel_n_q <= 1'b1; mosi_q <= 1'b0; xosc_q <= 1'b0;
            sym1_q <= 1'b0; sym0_q <= 1'b0; low_battery_o <= 1'b0;
        end else begin
            sclk_s <= {sclk_s[1:0], spi_i.sclk};
            sel_s  <= {sel_s[1:0], spi_i.sel_n};
            mosi_s <= {mosi_s[1:0], spi_i.mosi};
            xosc_s <= {xosc_s[1:0], oscillator_input_i};
            sym1_s <= {sym1_s[1:0], symbol_high_bit_input_i};
            sym0_s <= {sym0_s[1:0], symbol_low_bit_input_i};
            lob_s  <= {lob_s[1:0], low_battery_input_i};
            if (sclk_s[2] == sclk_s[1]) sclk_q <= sclk_s[2];
            if (sel_s[2] == sel_s[1]) sel_n_q <= sel_s[2];
            if (mosi_s[2] == mosi_s[1]) mosi_q <= mosi_s[2];
            if (xosc_s[2] == xosc_s[1]) xosc_q <= xosc_s[2];
            if (sym1_s[2] == sym1_s[1]) sym1_q <= sym1_s[2];
            if (sym0_s[2] == sym0_s[1]) sym0_q <= sym0_s[2];
            // The level is only passed on; battery sensing is done outside.
            if (lob_s[2] == lob_s[1]) low_battery_o <= lob_s[2];
        end
    end

    // The strap is a pin, so it is caught once, after its synchroniser has filled and its
    // last two stages agree; until then the internal oscillator stays selected.
    logic       strap_reg, strap_done;
    logic [2:0] strap_s;
    logic [1:0] strap_age;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strap_s    <= 3'h0;
            strap_age  <= 2'h0;
            strap_reg  <= 1'b0;
            strap_done <= 1'b0;
        end else begin
            strap_s <= {strap_s[1:0], oscillator_bypass_strap_i};
            if (strap_age != 2'h3) begin
                strap_age <= strap_age + 1'b1;
            end else if (!strap_done && strap_s[2] == strap_s[1]) begin
                strap_reg  <= strap_s[2];
                strap_done <= 1'b1;
            end
        end
    end

    // Internal oscillator model: toggles at 76.8 kHz from the reference clock.
    logic [CW-1:0] osc_cnt;
    logic          int_osc;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            osc_cnt <= '0;
            int_osc <= 1'b0;
        end else if (osc_cnt == CW'(HALF - 1)) begin
            osc_cnt <= '0;
            int_osc <= ~int_osc;
        end else begin
            osc_cnt <= osc_cnt + 1'b1;
        end
    end

    logic osc_sel, osc_prev;
    assign osc_sel = strap_reg ? xosc_q : int_osc;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            osc_prev               <= 1'b0;
            oscillator_output_o    <= 1'b0;
            divided_clock_output_o <= 1'b0;
        end else begin
            osc_prev <= osc_sel;
            // Bypassed oscillator leaves its output idle low.
            oscillator_output_o <= strap_reg ? 1'b0 : int_osc;
            if (osc_sel && !osc_prev) divided_clock_output_o <= ~divided_clock_output_o;
        end
    end

    // Symbol packing and a recovered clock toggling on each symbol change.
    logic [1:0] sym_now;
    assign sym_now = {sym1_q, sym0_q};
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            symbol_o                 <= 2'h0;
            recovered_symbol_clock_o <= 1'b0;
        end else begin
            symbol_o <= sym_now;
            // Retimed on ref_clk, so the output edge always falls on a ref_clk edge.
            if (sym_now != symbol_o) recovered_symbol_clock_o <= ~recovered_symbol_clock_o;
        end
    end

    // Control state machine and init counter.
    pdpi_state_t   state_reg;
    logic [CW-1:0] init_cnt;
    logic          sel_act, sclk_prev, sclk_rise, sclk_fall;
    assign sel_act   = !sel_n_q;
    assign sclk_rise = sel_act && sclk_q && !sclk_prev;
    assign sclk_fall = sel_act && !sclk_q && sclk_prev;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= PDPI_RESET;
            init_cnt  <= '0;
        end else begin
            unique case (state_reg)
                PDPI_RESET: state_reg <= PDPI_INIT;
                PDPI_INIT: begin
                    if (init_cnt == CW'(INIT_CYC - 1)) state_reg <= PDPI_READY;
                    else init_cnt <= init_cnt + 1'b1;
                end
                PDPI_READY: if (sel_act) state_reg <= PDPI_XFER;
                PDPI_XFER:  if (!sel_act) state_reg <= PDPI_READY;
            endcase
        end
    end

    // Full-duplex shifter, mode 0: sample on rise, shift out on fall.
    logic [W-1:0]         rx_sh, tx_sh;
    logic [$clog2(W)-1:0] bit_cnt;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_prev   <= 1'b0;
            rx_sh       <= '0;
            tx_sh       <= '1;
            bit_cnt     <= '0;
            rx_word_o   <= '0;
            rx_valid_o  <= 1'b0;
            miso_o      <= 1'b1;
            miso_oe_n_o <= 1'b1;
            ready_o     <= 1'b1;
        end else begin
            sclk_prev  <= sclk_q;
            rx_valid_o <= 1'b0;
            ready_o    <= (state_reg != PDPI_READY);
            miso_oe_n_o <= !(state_reg == PDPI_XFER && sel_act);
            if (state_reg != PDPI_XFER) begin
                bit_cnt <= '0;
                tx_sh   <= tx_word_i;
                miso_o  <= tx_word_i[W-1];
            end else if (sclk_rise) begin
                rx_sh   <= {rx_sh[W-2:0], mosi_q};
                bit_cnt <= bit_cnt + 1'b1;
                if (bit_cnt == ($clog2(W))'(W - 1)) begin
                    rx_word_o  <= {rx_sh[W-2:0], mosi_q};
                    rx_valid_o <= 1'b1;
                end
            end else if (sclk_fall) begin
                if (bit_cnt == '0) tx_sh <= tx_word_i;
                else tx_sh <= {tx_sh[W-2:0], 1'b1};
                miso_o <= (bit_cnt == '0) ? tx_word_i[W-1] : tx_sh[W-2];
            end
        end
    end

    // Receiver controls float until initialisation ends.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            receiver_control_outputs_o <= `PDPI_RX_CTRL_RST;
            receiver_control_oe_n_o    <= 8'hFF;
        end else begin
            receiver_control_outputs_o <= rx_ctrl_i;
            receiver_control_oe_n_o    <= (state_reg == PDPI_RESET || state_reg == PDPI_INIT)
                                          ? 8'hFF : 8'h00;
        end
    end

    property p_ready_high_in_init;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        (state_reg == PDPI_INIT) |=> ready_o;
    endproperty
    a_ready_high_in_init: assert property (p_ready_high_in_init)
        else $error("ready low during init");

    property p_ready_low_when_idle;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        (state_reg == PDPI_READY) |=> !ready_o;
    endproperty
    a_ready_low_when_idle: assert property (p_ready_low_when_idle)
        else $error("ready not low when idle");

    property p_miso_float_unselected;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        !sel_act |=> miso_oe_n_o;
    endproperty
    a_miso_float_unselected: assert property (p_miso_float_unselected)
        else $error("miso driven while unselected");

    property p_no_shift_unselected;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        !sel_act |=> $stable(rx_sh);
    endproperty
    a_no_shift_unselected: assert property (p_no_shift_unselected)
        else $error("shifted without select");

    property p_symbol_order;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        1'b1 |=> symbol_o == {$past(sym1_q), $past(sym0_q)};
    endproperty
    a_symbol_order: assert property (p_symbol_order)
        else $error("symbol bit order wrong");

    property p_recovered_symbol_clock_on_change;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        (sym_now != symbol_o) |=> $changed(recovered_symbol_clock_o);
    endproperty
    a_recovered_symbol_clock_on_change: assert property (p_recovered_symbol_clock_on_change)
        else $error("symbol clock missed a change");

    property p_divclk_half;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        (osc_sel && !osc_prev) |=> $changed(divided_clock_output_o);
    endproperty
    a_divclk_half: assert property (p_divclk_half)
        else $error("divided clock did not toggle");

    property p_rxctrl_float_init;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        (state_reg == PDPI_INIT) |=> (receiver_control_oe_n_o == 8'hFF);
    endproperty
    a_rxctrl_float_init: assert property (p_rxctrl_float_init)
        else $error("receiver controls driven in init");

    property p_rx_valid_in_xfer;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        rx_valid_o |-> $past(state_reg) == PDPI_XFER;
    endproperty
    a_rx_valid_in_xfer: assert property (p_rx_valid_in_xfer)
        else $error("word received outside transfer");
endmodule // pdpi_top
`default_nettype wire

// ### bench/pdpi_host_model.sv
// Host processor model that acts as SPI master towards the decoder.
`timescale 1ns/1ps
`default_nettype none
module pdpi_host_model (
    input  wire logic              ref_clk_i,
    input  wire logic              ready_i,
    input  wire logic              miso_i,
    output var  pdpi_pkg::pdpi_spi_in_t spi_o
);
    import pdpi_pkg::*;
    localparam int HALF = 8;
    initial spi_o = '{sclk: 1'b0, sel_n: 1'b1, mosi: 1'b0};
    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk_i);
        #2;
    endtask
    // Mode 0, MSB first; the clock stands low between frames.
    task automatic xfer(input logic [7:0] tx, input bit sel, output logic [7:0] rx,
                        output bit ok);
        int i;
        ok = 1'b0;
        for (i = 0; i < 400 && !ok; i++) begin
            ok = (ready_i === 1'b0);
            if (!ok) wait_clk(1);
        end
        spi_o.sel_n = !sel;
        wait_clk(HALF);
        for (i = 7; i >= 0; i--) begin
            spi_o.mosi = tx[i];
            wait_clk(HALF);
            rx[i] = miso_i;
            spi_o.sclk = 1'b1;
            wait_clk(HALF);
            spi_o.sclk = 1'b0;
        end
        wait_clk(HALF);
        spi_o.sel_n = 1'b1;
        spi_o.mosi = ~spi_o.mosi;
    endtask
endmodule // pdpi_host_model
`default_nettype wire

// ### bench/pdpi_top_tb.sv
// Self-checking testbench of the pager decoder pin interface.
`timescale 1ns/1ps
`default_nettype none
`include "pdpi_cfg.svh"
module pdpi_top_tb;
    import pdpi_pkg::*;
    localparam int INIT = 10;
    logic ref_clk_i = 1'b0;
    logic arst_n_i, osc_in, strap, low_battery_input, s_hi, s_lo;
    logic [7:0] tx_word, rx_ctrl, rx_word, rc_out, rc_oe_n;
    logic miso, miso_oe_n, ready, osc_out, div_clk, sym_clk, rx_valid, low_battery_input_o;
    logic [1:0] sym;
    pdpi_spi_in_t spi;
    int n_fail = 0, total_checks = 0, n_valid, n_div, n_sym, n_osc;
    // A released line shows the opposite level so a stale value never matches.
    wire logic miso_w = miso_oe_n ? ~miso : miso;
    pdpi_top #(.INIT_CYC(INIT), .W(8)) dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
        .oscillator_input_i(osc_in), .oscillator_bypass_strap_i(strap),
        .low_battery_input_i(low_battery_input), .symbol_high_bit_input_i(s_hi),
        .symbol_low_bit_input_i(s_lo), .spi_i(spi), .tx_word_i(tx_word), .rx_ctrl_i(rx_ctrl),
        .miso_o(miso), .miso_oe_n_o(miso_oe_n), .ready_o(ready), .oscillator_output_o(osc_out),
        .divided_clock_output_o(div_clk), .recovered_symbol_clock_o(sym_clk),
        .receiver_control_outputs_o(rc_out), .receiver_control_oe_n_o(rc_oe_n),
        .rx_word_o(rx_word), .rx_valid_o(rx_valid), .symbol_o(sym), .low_battery_o(low_battery_input_o));
    pdpi_host_model host (.ref_clk_i(ref_clk_i), .ready_i(ready), .miso_i(miso_w), .spi_o(spi));
    always #12.5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) if (rx_valid === 1'b1) n_valid++;
    always @(div_clk) n_div++;
    always @(sym_clk) n_sym++;
    always @(osc_out) n_osc++;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_in_reset();
        arst_n_i = 1'b0;
        host.wait_clk(12);
        chk(miso_oe_n, 1'b1);
        chk(ready, 1'b1);
        chk(rc_oe_n, 8'hFF);
        chk(rx_word, 8'h00);
        arst_n_i = 1'b1;
    endtask
    task automatic t_init(input logic [7:0] ctrl);
        int i;
        rx_ctrl = ctrl;
        host.wait_clk(INIT / 2);
        chk(ready, 1'b1);
        for (i = 0; i < INIT + 30 && ready !== 1'b0; i++) host.wait_clk(1);
        chk(ready, 1'b0);
        host.wait_clk(4);
        chk(rc_oe_n, 8'h00);
        chk(rc_out, ctrl);
    endtask
    // A window of eight oscillator half periods holds exactly eight image toggles and four
    // divided-clock toggles, whatever the phase at which it opens.
    task automatic t_int_osc();
        n_div = 0;
        n_osc = 0;
        host.wait_clk(`PDPI_OSC_HALF_CYC * 8);
        chk(n_osc, 8);
        chk(n_div, 4);
    endtask
    task automatic t_xfer(input logic [7:0] to_dev, input logic [7:0] from_dev);
        logic [7:0] rx;
        bit ok;
        tx_word = from_dev;
        n_valid = 0;
        host.xfer(to_dev, 1'b1, rx, ok);
        host.wait_clk(10);
        chk(ok, 1'b1);
        chk(n_valid, 1);
        chk(rx_word, to_dev);
        chk(rx, from_dev);
    endtask
    task automatic t_no_select();
        logic [7:0] rx;
        bit ok;
        n_valid = 0;
        host.xfer(8'h0F, 1'b0, rx, ok);
        host.wait_clk(10);
        chk(n_valid, 0);
        chk(miso_oe_n, 1'b1);
    endtask
    task automatic t_symbols();
        int c;
        n_sym = 0;
        for (c = 1; c <= 4; c++) begin
            {s_hi, s_lo} = c[1:0];
            host.wait_clk(8);
            chk(sym, c[1:0]);
        end
        chk(n_sym, 4);
        low_battery_input = 1'b1;
        host.wait_clk(8);
        chk(low_battery_input_o, 1'b1);
        low_battery_input = 1'b0;
        host.wait_clk(8);
        chk(low_battery_input_o, 1'b0);
    endtask
    task automatic t_bypass();
        strap = 1'b1;
        t_in_reset();
        t_init(8'hC3);
        n_div = 0;
        repeat (6) begin
            osc_in = 1'b1;
            host.wait_clk(10);
            osc_in = 1'b0;
            host.wait_clk(10);
        end
        chk(n_div, 6);
        chk(osc_out, 1'b0);
    endtask
    initial begin
        {arst_n_i, osc_in, strap, low_battery_input, s_hi, s_lo} = 6'h00;
        tx_word = 8'h00;
        rx_ctrl = 8'h00;
        t_in_reset();
        t_init(8'h5A);
        t_int_osc();
        t_xfer(8'hA5, 8'h3C);
        t_xfer(8'h81, 8'h7E);
        t_no_select();
        t_symbols();
        t_bypass();
        t_xfer(8'h00, 8'hFF);
        tally_and_finish();
    end
    initial begin
        #(25ns * 20000);
        n_fail++;
        tally_and_finish();
    end
endmodule // pdpi_top_tb
`default_nettype wire
